// file: shared/pfc_params.svh
// constants for the pixel format converter
`ifndef PFC_PARAMS_SVH
`define PFC_PARAMS_SVH
// output format codes
`define PFC_FMT_RGB32    3'h0
`define PFC_FMT_RGB24    3'h1
`define PFC_FMT_RGB16    3'h2
`define PFC_FMT_YUY2     3'h3
`define PFC_FMT_Y41P     3'h4
`define PFC_FMT_PLANAR2  3'h5
`define PFC_FMT_PLANAR1  3'h6
`define PFC_FMT_Y8       3'h7
// fixed point coefficients, scaled by 256
`define PFC_K_Y          12'h12a
`define PFC_K_RCR        12'h199
`define PFC_K_GCR        12'h0d0
`define PFC_K_GCB        12'h064
`define PFC_K_BCB        12'h204
`define PFC_Y_OFS        8'h10
`define PFC_C_OFS        8'h80
`define PFC_FRAC_BITS    8
`define PFC_FIFO_DEPTH   32
`define PFC_STAT_PXV     4'h0
`endif

// file: shared/pfc_pkg.sv
// types for the pixel format converter
package pfc_pkg;
  typedef struct packed {
    logic [7:0] y;
    logic [7:0] c;
    logic       is_cb;
  } pfc_pix_in_t;
  typedef struct packed {
    logic [3:0]  status;
    logic [31:0] pixel_word;
  } pfc_fifo_word_t;
endpackage

// file: core/pfc_fifo.sv
// small synchronous fifo for the converter output
`timescale 1ns/100ps
module pfc_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, rd_q;
  logic [AW:0]      cnt_q;
  logic             push, pop;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  // storage has no reset: contents only read when counted valid
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  // pointers and occupancy
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // pfc_fifo

// file: core/pfc_top.sv
// pixel format converter: 4:2:2 in, formatted words into the output fifo
`timescale 1ns/100ps
`include "pfc_params.svh"
module pfc_top import pfc_pkg::*; #(
  parameter int DEPTH = `PFC_FIFO_DEPTH
) (
  input  wire logic                 ref_clk,
  input  wire logic                 resetn,
  input  wire logic [16:0]          pix_in,
  input  wire logic                 pix_valid,
  input  wire logic                 line_start,
  input  wire logic [2:0]           out_format,
  input  wire logic                 gamma_remove,
  input  wire logic                 byte_swap,
  input  wire logic                 word_swap,
  input  wire logic                 vbi_capture,
  output logic                      pix_ready,
  output logic [35:0]               fifo_input_word,
  output logic                      out_valid,
  input  wire logic                 out_ready
);
  // ==========================================================
  // input stage: collect a 2-pixel group (y0 cb y1 cr)
  // ==========================================================
  pfc_pix_in_t in_s;
  assign in_s = pix_in;
  logic [7:0] y0_q, y1_q, cb_q, cr_q, pcb_q, pcr_q, ny_q, ncb_q, y0_prev_q;
  logic [1:0] ph_q;
  logic       have_prev_q, grp_q, first_q;
  logic       fifo_ready;
  logic       adv;
  assign adv = pix_valid && pix_ready;
  // group capture; is_cb selects y0/cb, otherwise y1/cr (ph_q stays 0)
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ph_q <= 2'h0;
      grp_q <= 1'b0;
      y0_q <= 8'h00;
      y1_q <= 8'h00;
      cb_q <= 8'h80;
      cr_q <= 8'h80;
    end else begin
      grp_q <= 1'b0;
      if (line_start) begin
        ph_q <= 2'h0;
      end else if (adv) begin
        if (in_s.is_cb) begin
          y0_q <= in_s.y;
          cb_q <= in_s.c;
        end else begin
          y1_q <= in_s.y;
          cr_q <= in_s.c;
          grp_q <= 1'b1;
        end
      end
    end
  end
  // previous group chroma for interpolation (one group of lookahead)
  always_ff @(posedge ref_clk) begin
    if (!resetn || line_start) begin
      pcb_q <= 8'h80;
      pcr_q <= 8'h80;
      have_prev_q <= 1'b0;
      first_q <= 1'b1;
    end else if (grp_q) begin
      pcb_q <= cb_q;
      pcr_q <= cr_q;
      have_prev_q <= 1'b1;
      first_q <= 1'b0;
    end
  end
  // ==========================================================
  // colour conversion
  // ==========================================================
  function automatic logic [7:0] pfc_clamp(input logic signed [21:0] v);
    logic signed [21:0] s;
    s = v >>> `PFC_FRAC_BITS;
    if (s < 0) begin
      return 8'h00;
    end else if (s > 22'sd255) begin
      return 8'hff;
    end
    return s[7:0];
  endfunction
  function automatic logic [23:0] pfc_rgb(input logic [7:0] y, input logic [7:0] cb, input logic [7:0] cr);
    logic signed [21:0] yt, cbt, crt, r, g, b;
    yt  = $signed({14'h0, y}) - $signed({14'h0, `PFC_Y_OFS});
    cbt = $signed({14'h0, cb}) - $signed({14'h0, `PFC_C_OFS});
    crt = $signed({14'h0, cr}) - $signed({14'h0, `PFC_C_OFS});
    yt  = yt * $signed({10'h0, `PFC_K_Y});
    r = yt + crt * $signed({10'h0, `PFC_K_RCR});
    g = yt - crt * $signed({10'h0, `PFC_K_GCR}) - cbt * $signed({10'h0, `PFC_K_GCB});
    b = yt + cbt * $signed({10'h0, `PFC_K_BCB});
    return {pfc_clamp(r), pfc_clamp(g), pfc_clamp(b)};
  endfunction
  // gamma removal approximated by squaring law, same for both fields
  function automatic logic [7:0] pfc_gamma(input logic [7:0] v, input logic en);
    logic [15:0] sq;
    sq = v * v;
    return en ? sq[15:8] : v;
  endfunction
  logic [7:0] cb_odd, cr_odd;
  logic       is_rgb;
  logic [23:0] rgb0, rgb1, rgb0_g, rgb1_g;
  // even chroma direct, odd chroma averaged with the next even sample
  assign cb_odd = 8'(({1'b0, pcb_q} + {1'b0, cb_q}) >> 1);
  assign cr_odd = 8'(({1'b0, pcr_q} + {1'b0, cr_q}) >> 1);
  assign is_rgb = (out_format == `PFC_FMT_RGB32) || (out_format == `PFC_FMT_RGB24) ||
                  (out_format == `PFC_FMT_RGB16);
  // previous group pixels: even uses its own chroma, odd uses averages
  assign rgb0 = pfc_rgb(ny_q, pcb_q, pcr_q);
  assign rgb1 = pfc_rgb(y0_prev_q, cb_odd, cr_odd);
  assign rgb0_g = {pfc_gamma(rgb0[23:16], gamma_remove && is_rgb), pfc_gamma(rgb0[15:8], gamma_remove && is_rgb),
                   pfc_gamma(rgb0[7:0], gamma_remove && is_rgb)};
  assign rgb1_g = {pfc_gamma(rgb1[23:16], gamma_remove && is_rgb), pfc_gamma(rgb1[15:8], gamma_remove && is_rgb),
                   pfc_gamma(rgb1[7:0], gamma_remove && is_rgb)};
  // luma of previous group held for the delayed conversion
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ny_q <= 8'h10;
      y0_prev_q <= 8'h10;
      ncb_q <= 8'h80;
    end else if (grp_q) begin
      ny_q <= y0_q;
      y0_prev_q <= y1_q;
      ncb_q <= cb_q;
    end
  end
  // ==========================================================
  // word assembly
  // ==========================================================
  logic [31:0] pw;
  logic        pw_ok;
  logic [1:0]  grp_cnt_q;
  logic [7:0]  cbsum, crsum;
  // 4:1:1: sum of position n and n+2, saturated to a byte
  assign cbsum = ({1'b0, pcb_q} + {1'b0, cb_q}) > 9'h0ff ? 8'hff : 8'(pcb_q + cb_q);
  assign crsum = ({1'b0, pcr_q} + {1'b0, cr_q}) > 9'h0ff ? 8'hff : 8'(pcr_q + cr_q);
  always_comb begin
    pw = 32'h0;
    pw_ok = 1'b0;
    unique case (out_format)
      `PFC_FMT_RGB32: begin
        pw = {8'h00, rgb0_g};
        pw_ok = grp_q && have_prev_q;
      end
      `PFC_FMT_RGB24, `PFC_FMT_RGB16: begin
        pw = {rgb1_g[15:8], rgb0_g};
        pw_ok = grp_q && have_prev_q;
      end
      `PFC_FMT_YUY2, `PFC_FMT_PLANAR2: begin
        // planar words carry 4:2:2 data, split downstream
        pw = {cr_q, y1_q, cb_q, y0_q};
        pw_ok = grp_q;
      end
      `PFC_FMT_Y41P, `PFC_FMT_PLANAR1: begin
        pw = {crsum, y1_q, cbsum, y0_q};
        pw_ok = grp_q && have_prev_q && !grp_cnt_q[0];
      end
      `PFC_FMT_Y8: begin
        pw = {y1_q, y0_q, ny_q, y0_prev_q};
        pw_ok = grp_q && grp_cnt_q[0];
      end
    endcase
  end
  // group counter for 4:1:1 positions 0,4,8
  always_ff @(posedge ref_clk) begin
    if (!resetn || line_start) begin
      grp_cnt_q <= 2'h0;
    end else if (grp_q) begin
      grp_cnt_q <= grp_cnt_q + 2'h1;
    end
  end
  // ==========================================================
  // byte remap and fifo
  // ==========================================================
  logic bs, ws;
  logic [31:0] sw;
  assign bs = byte_swap && !vbi_capture;
  assign ws = word_swap && !vbi_capture;
  // lane 0 holds the first scan-line byte only when neither byte nor word swap is in effect; in Y8 only under byte swap alone (vbi_capture forces both off)
  always_comb begin
    unique case ({ws, bs})
      2'b00: sw = pw;
      2'b01: sw = {pw[23:16], pw[31:24], pw[7:0], pw[15:8]};
      2'b10: sw = {pw[15:0], pw[31:16]};
      2'b11: sw = {pw[7:0], pw[15:8], pw[23:16], pw[31:24]};
    endcase
  end
  pfc_fifo_word_t fw;
  assign fw.status = `PFC_STAT_PXV;
  assign fw.pixel_word = sw;
  logic [35:0] fo_data;
  logic        fo_valid;
  // fifo decouples converter from the dma side
  pfc_fifo #(.WIDTH(36), .DEPTH(DEPTH)) u_fifo (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .in_data  (fw),
    .in_valid (pw_ok),
    .in_ready (fifo_ready),
    .out_data (fo_data),
    .out_valid(fo_valid),
    .out_ready(out_ready || !out_valid)
  );
  // registered output stage and stall: input stops while fifo full
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      fifo_input_word <= 36'h0;
      out_valid <= 1'b0;
      pix_ready <= 1'b0;
    end else begin
      pix_ready <= fifo_ready && !grp_q;
      if (out_ready || !out_valid) begin
        out_valid <= fo_valid;
        fifo_input_word <= fo_data;
      end
    end
  end
endmodule // pfc_top

// file: testbench/pfc_chk.sv
// port assertions for the pixel format converter
`timescale 1ns/100ps
`include "pfc_params.svh"
module pfc_chk (
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic [16:0] pix_in,
  input wire logic        pix_valid,
  input wire logic [2:0]  out_format,
  input wire logic        byte_swap,
  input wire logic        word_swap,
  input wire logic        pix_ready,
  input wire logic [35:0] fifo_input_word,
  input wire logic        out_valid,
  input wire logic        out_ready
);
  // ==========================================
  // stream checks, all in the pixel clock domain
  default clocking cb_main @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_status_zero: assert property (out_valid |-> fifo_input_word[35:32] == `PFC_STAT_PXV)
    else $error("status nibble not zero");
  a_word_holds: assert property (out_valid && !out_ready |=> out_valid && $stable(fifo_input_word))
    else $error("word changed while stalled");
  a_valid_drop_taken: assert property ($fell(out_valid) |-> $past(out_ready))
    else $error("word withdrawn before taken");
  // reset must be watched while it is asserted, so no disable here
  a_reset_quiet: assert property (disable iff (1'b0) !resetn |=> !out_valid && !pix_ready)
    else $error("outputs active in reset");
  a_ready_after_reset: assert property ($rose(resetn) |-> ##[1:2] pix_ready)
    else $error("input not ready after reset");
  a_alpha_zero: assert property (out_valid && out_format == `PFC_FMT_RGB32 && !byte_swap && !word_swap
    |-> fifo_input_word[31:24] == 8'h00)
    else $error("alpha byte not zero");
  a_pair_gap: assert property (pix_valid && pix_ready && !pix_in[0] |=> ##1 !pix_ready)
    else $error("ready not dropped after pair");
  a_pair_output: assert property (pix_valid && pix_ready && !pix_in[0] && out_format == `PFC_FMT_YUY2
    |-> ##[1:40] out_valid)
    else $error("pair produced no word");
endmodule // pfc_chk

// file: testbench/pfc_sink.sv
// drain side model: takes output words, stalls on request
`timescale 1ns/100ps
module pfc_sink (
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        stall,
  input wire logic        out_valid,
  input wire logic [35:0] fifo_input_word,
  output logic            out_ready
);
  logic [35:0] got[$];
  // a stall stands for a busy host bus
  assign out_ready = !stall;
  // keep every accepted word in arrival order
  always @(posedge ref_clk) begin
    if (!resetn) got.delete();
    else if (out_valid && out_ready) got.push_back(fifo_input_word);
  end
endmodule // pfc_sink

// file: testbench/test_pfc_top.sv
// self-checking bench for the pixel format converter
`timescale 1ns/100ps
`include "pfc_params.svh"
module test_pfc_top;
  logic ref_clk = 1'h0, resetn = 1'h0, pix_valid = 1'h0, line_start = 1'h0, gamma_remove = 1'h0;
  logic byte_swap = 1'h0, word_swap = 1'h0, vbi_capture = 1'h0, stall = 1'h0;
  logic pix_ready, out_valid, out_ready;
  logic [16:0] pix_in = 17'h0;
  logic [2:0]  out_format = `PFC_FMT_YUY2;
  logic [35:0] fifo_input_word;
  logic [35:0] exp_q[$];
  logic [31:0] w;
  // gray, low clamp, gray with gamma removal
  logic [31:0] rin[3] = '{32'h80908090, 32'h10108010, 32'h80908090};
  logic [31:0] rex[3] = '{32'h00959595, 32'h00005b00, 32'h00565656};
  int fails = 0, checks = 0;
  always #2 ref_clk = ~ref_clk;
  pfc_top DUT (.ref_clk(ref_clk), .resetn(resetn), .pix_in(pix_in), .pix_valid(pix_valid),
    .line_start(line_start), .out_format(out_format), .gamma_remove(gamma_remove), .byte_swap(byte_swap),
    .word_swap(word_swap), .vbi_capture(vbi_capture), .pix_ready(pix_ready),
    .fifo_input_word(fifo_input_word), .out_valid(out_valid), .out_ready(out_ready));
  pfc_sink P (.ref_clk(ref_clk), .resetn(resetn), .stall(stall), .out_valid(out_valid),
    .fifo_input_word(fifo_input_word), .out_ready(out_ready));
  // ==========================================
  // access tasks
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // hold the pixel until an edge samples ready high
  task automatic put_pix(input logic [7:0] y, input logic [7:0] c, input logic cb);
    pix_in = {y, c, cb};
    while (pix_ready !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    #1;
  endtask
  // packed pair {cr, y1, cb, y0}
  task automatic pair(input logic [31:0] p);
    put_pix(p[7:0], p[15:8], 1'b1);
    put_pix(p[23:16], p[31:24], 1'b0);
  endtask
  task automatic lstart();
    line_start = 1'h1;
    @(posedge ref_clk);
    #1;
    line_start = 1'h0;
  endtask
  // wait for all expected words, bounded, then compare in order
  task automatic drain();
    pix_valid = 1'h0;
    for (int i = 0; i < 600 && P.got.size() < exp_q.size(); i++) @(posedge ref_clk);
    #1;
    chk(36'(P.got.size()), 36'(exp_q.size()));
    while (exp_q.size() > 0) chk(P.got.pop_front(), exp_q.pop_front());
  endtask
  function automatic logic [35:0] swp(input logic [31:0] d, input logic b, input logic ws);
    logic [31:0] t;
    t = b ? {d[23:16], d[31:24], d[7:0], d[15:8]} : d;
    return {`PFC_STAT_PXV, ws ? {t[15:0], t[31:16]} : t};
  endfunction
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ==========================================
  // scenarios
  initial begin
    repeat (5) @(posedge ref_clk);
    #1 resetn = 1'h1;
    @(posedge ref_clk);
    #1;
    // packed luma/chroma under every swap mode, gamma left on to prove it is ignored
    gamma_remove = 1'h1;
    for (int m = 0; m < 5; m++) begin
      vbi_capture = (m == 4);
      {word_swap, byte_swap} = (m == 4) ? 2'h3 : m[1:0];
      lstart();
      pix_valid = 1'h1;
      for (int i = 0; i < 2; i++) begin
        w = 32'h90406020 + {4{i[7:0]}};
        pair(w);
        exp_q.push_back(swp(w, byte_swap && m != 4, word_swap && m != 4));
      end
      drain();
    end
    {vbi_capture, word_swap, byte_swap} = 3'h0;
    // rgb: first pair of a line only primes the interpolator
    out_format = `PFC_FMT_RGB32;
    for (int c = 0; c < 3; c++) begin
      gamma_remove = (c == 2);
      lstart();
      pix_valid = 1'h1;
      repeat (3) pair(rin[c]);
      repeat (2) exp_q.push_back({`PFC_STAT_PXV, rex[c]});
      drain();
    end
    // planar 4:2:2: one line of 16 pixels, width kept a multiple of 16
    out_format = `PFC_FMT_PLANAR2;
    lstart();
    pix_valid = 1'h1;
    for (int i = 0; i < 8; i++) begin
      w = 32'h80508040 + {4{i[7:0]}};
      pair(w);
      exp_q.push_back(swp(w, 1'b0, 1'b0));
    end
    drain();
    // fill the buffer while the host side stalls, then let it drain
    gamma_remove = 1'h0;
    out_format = `PFC_FMT_YUY2;
    stall = 1'h1;
    lstart();
    fork
      begin
        pix_valid = 1'h1;
        for (int i = 0; i < 40; i++) begin
          w = 32'h80108010 + {4{i[7:0]}};
          pair(w);
          exp_q.push_back(swp(w, 1'b0, 1'b0));
        end
      end
      begin
        repeat (300) @(posedge ref_clk);
        #1;
        chk({35'h0, pix_ready}, 36'h0);
        stall = 1'h0;
      end
    join
    drain();
    conclude();
  end
  // cut a hang short
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    conclude();
  end
endmodule // test_pfc_top
bind pfc_top pfc_chk u_chk (.ref_clk(ref_clk), .resetn(resetn), .pix_in(pix_in), .pix_valid(pix_valid),
  .out_format(out_format), .byte_swap(byte_swap), .word_swap(word_swap), .pix_ready(pix_ready),
  .fifo_input_word(fifo_input_word), .out_valid(out_valid), .out_ready(out_ready));
